// ---- shared/sfp_consts.svh ----
// constants shared by the serial memory protection and access block
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH

// command opcodes, first byte after select
`define SFP_OP_LATCH_SET    8'h06
`define SFP_OP_LATCH_CLEAR  8'h04
`define SFP_OP_STATUS_READ  8'h05
`define SFP_OP_STATUS_WRITE 8'h01
`define SFP_OP_MEM_READ     8'h03
`define SFP_OP_MEM_WRITE    8'h02

// memory geometry
`define SFP_ADDR_W          13
`define SFP_ADDR_HI_W       5
`define SFP_DATA_W          8
`define SFP_WORD_W          21
`define SFP_ADDR_STEP       13'h0001

// status register bit positions and reset value
`define SFP_SR_GUARD_EN     7
`define SFP_SR_PROT_HI      3
`define SFP_SR_PROT_LO      2
`define SFP_SR_WLATCH       1
`define SFP_SR_RESET        8'h00

// block protection selector codes and lower bounds
`define SFP_BP_NONE         2'h0
`define SFP_BP_QUARTER      2'h1
`define SFP_BP_HALF         2'h2
`define SFP_BP_ALL          2'h3
`define SFP_QTR_BASE        13'h1800
`define SFP_HALF_BASE       13'h1000

// bit counter value of the eighth bit of a byte
`define SFP_BIT_LAST        3'h7

// depth of the write buffer
`define SFP_BUF_DEPTH       2

`endif

// ---- shared/sfp_pkg.sv ----
// types shared by the serial memory protection and access block
package sfp_pkg;

	// transfer phases, gray coded along idle, command, address, memory write
	typedef enum logic [2:0] {
		SFP_IDLE    = 3'h0,
		SFP_CMD     = 3'h1,
		SFP_ADDR    = 3'h3,
		SFP_MEM_WR  = 3'h2,
		SFP_MEM_RD  = 3'h6,
		SFP_STAT_RD = 3'h7,
		SFP_STAT_WR = 3'h5,
		SFP_IGNORE  = 3'h4
	} sfp_phase_type;

endpackage

// ---- shared/sfp_buf_if.sv ----
// handshake bundle between the serial front end and its write buffer
`timescale 1ns/1ps
interface sfp_buf_if #(
	parameter int WIDTH = 21
);
	logic             inValid;   // source offers a word
	logic             inReady;   // buffer has room
	logic [WIDTH-1:0] inData;    // word offered
	logic             outValid;  // buffer holds a word
	logic             outReady;  // drain takes the word
	logic [WIDTH-1:0] outData;   // oldest word

	modport source (output inValid, output inData, input inReady);
	modport store  (input inValid, input inData, output inReady,
		output outValid, output outData, input outReady);
	modport drain  (input outValid, input outData, output outReady);
endinterface

// ---- src/sfp_two_buf.sv ----
// small fifo that holds committed write words until the array takes them
`timescale 1ns/1ps
`include "sfp_consts.svh"
module sfp_two_buf #(
	parameter int WIDTH = `SFP_WORD_W,
	parameter int DEPTH = `SFP_BUF_DEPTH
) (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	sfp_buf_if.store  bus
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// whole state of the buffer
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] slots;  // storage
		logic [PW-1:0]               wrPtr;  // next slot to fill
		logic [PW-1:0]               rdPtr;  // oldest slot
		logic [PW:0]                 count;  // words held
	} sfp_buf_state_type;

	sfp_buf_state_type bufReg;   // registered state
	sfp_buf_state_type bufNext;  // next state

	// pointer advance with wrap at the last slot
	function automatic logic [PW-1:0] sfp_bump(input logic [PW-1:0] p);
		sfp_bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	logic doPush;  // word accepted this cycle
	logic doPop;   // word handed out this cycle

	// honest full and empty flags drive both handshakes
	assign bus.inReady  = (bufReg.count != (PW + 1)'(DEPTH));
	assign bus.outValid = (bufReg.count != '0);
	assign bus.outData  = bufReg.slots[bufReg.rdPtr];
	assign doPush       = bus.inValid & bus.inReady;
	assign doPop        = bus.outValid & bus.outReady;

	// push and pop may share a cycle; count then stays
	always_comb begin
		bufNext = bufReg;
		if (doPush) begin
			bufNext.slots[bufReg.wrPtr] = bus.inData;
			bufNext.wrPtr               = sfp_bump(bufReg.wrPtr);
		end
		if (doPop) begin
			bufNext.rdPtr = sfp_bump(bufReg.rdPtr);
		end
		if (doPush && !doPop) begin
			bufNext.count = bufReg.count + (PW + 1)'(1);
		end else if (doPop && !doPush) begin
			bufNext.count = bufReg.count - (PW + 1)'(1);
		end
	end

	// synchronous reset empties the buffer
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bufReg <= '0;
		end else begin
			bufReg <= bufNext;
		end
	end
endmodule

// ---- src/sfp_fram_slave.sv ----
// serial slave front end: commands, status, protection, burst access, pause
//
// Notes on behaviour
// - first byte decodes command; unknown ignored
// - sample on rising, drive on falling edges
// - status reads stored selectors after reset, latch zero
// - bits 0, 4-6 read zero, never written
// - latch bit resets zero, status write ignores
// - latch set only by its command; cleared by its command, reset or write frame end
// - select rise after write-type commands clears latch
// - protection selectors kept in nonvolatile storage
// - selector decode: none, quarter, half, all
// - guard enable plus low pin blocks status write
// - array writes need latch and unprotected address
// - status read returns one byte, msb first
// - permitted status write updates bits 7,3,2
// - two address bytes, low 13 bits used
// - burst write stores, increments, wraps to zero
// - byte committed at eighth bit, partial dropped
// - protected address stops burst, drops later bytes
// - select rise ends memory write
// - read data follows address, input ignored
// - burst read increments address, wraps to zero
// - select rise ends read, output released
// - pause pin freezes transfer while clock low
`timescale 1ns/1ps
`include "sfp_consts.svh"
module sfp_fram_slave (
	input  wire logic                       clk_sys,
	input  wire logic                       rst_n,
	input  wire logic                       csN,
	input  wire logic                       sck,
	input  wire logic                       si,
	input  wire logic                       holdN,
	input  wire logic                       wpN,
	output wire logic                       soOut,
	output wire logic                       soOe,
	output wire logic [`SFP_ADDR_W-1:0]     memRdAddr,
	input  wire logic [`SFP_DATA_W-1:0]     memRdData,
	output wire logic                       memWrValid,
	input  wire logic                       memWrReady,
	output wire logic [`SFP_ADDR_W-1:0]     memWrAddr,
	output wire logic [`SFP_DATA_W-1:0]     memWrData,
	input  wire logic [2:0]                 nvProtIn,
	output wire logic [2:0]                 nvProtOut,
	output wire logic                       nvProtStore
);

	// whole state of the front end
	typedef struct packed {
		logic [2:0]               sckSync;    // [0] first, [1] second, [2] previous
		logic [2:0]               csSync;     // same layout for select
		logic [2:0]               holdSync;   // same layout for pause pin
		logic [1:0]               siSync;     // data input synchroniser
		logic [1:0]               wpSync;     // guard pin synchroniser
		sfp_pkg::sfp_phase_type   phase;      // transfer phase
		logic [2:0]               bitCnt;     // bit within current byte
		logic [7:0]               shiftIn;    // incoming bits
		logic [7:0]               shiftOut;   // outgoing bits
		logic [`SFP_ADDR_W-1:0]   addr;       // current array address
		logic                     addrLow;    // second address byte due
		logic                     loadPend;   // fetch next read byte
		logic                     outActive;  // falling edges drive output
		logic                     writeOp;    // command clears latch at end
		logic                     stopped;    // burst hit a protected block
		logic                     wLatch;     // write_latch_flag
		logic                     guardEn;    // guard_pin_enable
		logic                     protHi;     // protect_sel_hi
		logic                     protLo;     // protect_sel_lo
		logic                     soBit;      // bit on the output pin
		logic                     oeDrv;      // output driven unless paused
		logic                     paused;     // pause pin holds transfer
		logic                     nvLoaded;   // selectors fetched from storage
		logic                     nvStore;    // one-cycle store strobe
		logic                     pendValid;  // committed word waits for buffer
		logic [`SFP_WORD_W-1:0]   pendWord;   // address and data
	} sfp_slave_state_type;

	sfp_slave_state_type slaveReg;   // registered state
	sfp_slave_state_type slaveNext;  // next state

	sfp_buf_if #(.WIDTH(`SFP_WORD_W)) wrBus ();  // path to the write buffer

	// status byte assembled from the live flags; unused bits stay zero
	function automatic logic [7:0] sfp_status(input sfp_slave_state_type s);
		logic [7:0] v;
		v                   = `SFP_SR_RESET;
		v[`SFP_SR_GUARD_EN] = s.guardEn;
		v[`SFP_SR_PROT_HI]  = s.protHi;
		v[`SFP_SR_PROT_LO]  = s.protLo;
		v[`SFP_SR_WLATCH]   = s.wLatch;
		sfp_status          = v;
	endfunction

	// protected-range check for one address
	function automatic logic sfp_is_prot(input logic [`SFP_ADDR_W-1:0] a,
		input logic [1:0] sel);
		logic r;
		r = 1'b0;
		unique case (sel)
			`SFP_BP_NONE:    r = 1'b0;
			`SFP_BP_QUARTER: r = (a >= `SFP_QTR_BASE);
			`SFP_BP_HALF:    r = (a >= `SFP_HALF_BASE);
			`SFP_BP_ALL:     r = 1'b1;
		endcase
		sfp_is_prot = r;
	endfunction

	// synchronised pin levels and their edges, all taken from second stages
	logic sckNow;    // clock level
	logic sckRise;   // clock rising
	logic sckFall;   // clock falling
	logic csRise;    // select released
	logic csFall;    // select asserted
	logic holdRise;  // pause released
	logic holdFall;  // pause asserted
	logic siNow;     // data bit
	logic wpLow;     // guard pin asserted
	logic [7:0] inByte;  // byte completed on this rising edge

	assign sckNow   = slaveReg.sckSync[1];
	assign sckRise  = slaveReg.sckSync[1] & ~slaveReg.sckSync[2];
	assign sckFall  = ~slaveReg.sckSync[1] & slaveReg.sckSync[2];
	assign csRise   = slaveReg.csSync[1] & ~slaveReg.csSync[2];
	assign csFall   = ~slaveReg.csSync[1] & slaveReg.csSync[2];
	assign holdRise = slaveReg.holdSync[1] & ~slaveReg.holdSync[2];
	assign holdFall = ~slaveReg.holdSync[1] & slaveReg.holdSync[2];
	assign siNow    = slaveReg.siSync[1];
	assign wpLow    = ~slaveReg.wpSync[1];
	assign inByte   = {slaveReg.shiftIn[6:0], siNow};

	// next-state logic: synchronisers, pause, select framing, byte engine
	always_comb begin
		slaveNext         = slaveReg;
		slaveNext.nvStore = 1'b0;
		// two flip-flops on every pin before use; third stage is history
		slaveNext.sckSync  = {slaveReg.sckSync[1:0], sck};
		slaveNext.csSync   = {slaveReg.csSync[1:0], csN};
		slaveNext.holdSync = {slaveReg.holdSync[1:0], holdN};
		slaveNext.siSync   = {slaveReg.siSync[0], si};
		slaveNext.wpSync   = {slaveReg.wpSync[0], wpN};

		// selectors come back from storage once after reset
		if (!slaveReg.nvLoaded) begin
			slaveNext.guardEn  = nvProtIn[2];
			slaveNext.protHi   = nvProtIn[1];
			slaveNext.protLo   = nvProtIn[0];
			slaveNext.nvLoaded = 1'b1;
		end

		// waiting word leaves as soon as the buffer has room
		if (slaveReg.pendValid && wrBus.inReady) begin
			slaveNext.pendValid = 1'b0;
		end

		// pause pin only counts while the clock is low
		if (holdFall && !sckNow) begin
			slaveNext.paused = 1'b1;
		end else if (holdRise && !sckNow) begin
			slaveNext.paused = 1'b0;
		end

		// everything below is frozen during a pause, select included
		if (!slaveReg.paused) begin
			if (csRise) begin
				// end of frame closes any read or write
				slaveNext.phase     = sfp_pkg::SFP_IDLE;
				slaveNext.oeDrv     = 1'b0;
				slaveNext.outActive = 1'b0;
				slaveNext.loadPend  = 1'b0;
				if (slaveReg.writeOp) begin
					slaveNext.wLatch = 1'b0;
				end
			end else if (csFall) begin
				// new frame; mode 0 and 3 share the same edge handling
				slaveNext.phase     = sfp_pkg::SFP_CMD;
				slaveNext.bitCnt    = '0;
				slaveNext.writeOp   = 1'b0;
				slaveNext.stopped   = 1'b0;
				slaveNext.addrLow   = 1'b0;
				slaveNext.outActive = 1'b0;
				slaveNext.loadPend  = 1'b0;
			end else if (slaveReg.phase != sfp_pkg::SFP_IDLE) begin
				// fetch the next read byte well before its first falling edge
				if (slaveReg.loadPend) begin
					slaveNext.shiftOut = memRdData;
					slaveNext.addr     = slaveReg.addr + `SFP_ADDR_STEP;
					slaveNext.loadPend = 1'b0;
				end
				// output changes on the falling edge only
				if (sckFall && slaveReg.outActive) begin
					slaveNext.soBit    = slaveReg.shiftOut[7];
					slaveNext.shiftOut = {slaveReg.shiftOut[6:0], 1'b0};
					slaveNext.oeDrv    = 1'b1;
				end
				// input sampled on the rising edge
				if (sckRise) begin
					slaveNext.shiftIn = inByte;
					slaveNext.bitCnt  = slaveReg.bitCnt + 3'h1;
					if (slaveReg.bitCnt == `SFP_BIT_LAST) begin
						unique case (slaveReg.phase)
							sfp_pkg::SFP_CMD: begin
								// only the first byte of a frame is a command
								slaveNext.phase = sfp_pkg::SFP_IGNORE;
								unique case (inByte)
									`SFP_OP_LATCH_SET: begin
										slaveNext.wLatch = 1'b1;
									end
									`SFP_OP_LATCH_CLEAR: begin
										slaveNext.wLatch  = 1'b0;
										slaveNext.writeOp = 1'b1;
									end
									`SFP_OP_STATUS_READ: begin
										slaveNext.shiftOut  = sfp_status(slaveReg);
										slaveNext.outActive = 1'b1;
										slaveNext.phase     = sfp_pkg::SFP_STAT_RD;
									end
									`SFP_OP_STATUS_WRITE: begin
										slaveNext.writeOp = 1'b1;
										slaveNext.phase   = sfp_pkg::SFP_STAT_WR;
									end
									`SFP_OP_MEM_READ: begin
										slaveNext.phase = sfp_pkg::SFP_ADDR;
									end
									`SFP_OP_MEM_WRITE: begin
										slaveNext.writeOp = 1'b1;
										slaveNext.phase   = sfp_pkg::SFP_ADDR;
									end
									default: begin
										// unknown opcode: rest of frame ignored
										slaveNext.phase = sfp_pkg::SFP_IGNORE;
									end
								endcase
							end
							sfp_pkg::SFP_ADDR: begin
								// top three bits of the first byte are dropped
								if (!slaveReg.addrLow) begin
									slaveNext.addr[`SFP_ADDR_W-1:8] =
										inByte[`SFP_ADDR_HI_W-1:0];
									slaveNext.addrLow = 1'b1;
								end else begin
									slaveNext.addr[7:0] = inByte;
									slaveNext.addrLow   = 1'b0;
									if (slaveReg.writeOp) begin
										slaveNext.phase = sfp_pkg::SFP_MEM_WR;
									end else begin
										slaveNext.phase     = sfp_pkg::SFP_MEM_RD;
										slaveNext.loadPend  = 1'b1;
										slaveNext.outActive = 1'b1;
									end
								end
							end
							sfp_pkg::SFP_STAT_RD: begin
								// exactly one byte, then the pin is let go
								slaveNext.phase     = sfp_pkg::SFP_IGNORE;
								slaveNext.outActive = 1'b0;
								slaveNext.oeDrv     = 1'b0;
							end
							sfp_pkg::SFP_STAT_WR: begin
								// guard pin only counts when guard enable is set
								if (slaveReg.wLatch && !(slaveReg.guardEn && wpLow)) begin
									slaveNext.guardEn = inByte[`SFP_SR_GUARD_EN];
									slaveNext.protHi  = inByte[`SFP_SR_PROT_HI];
									slaveNext.protLo  = inByte[`SFP_SR_PROT_LO];
									slaveNext.nvStore = 1'b1;
								end
								slaveNext.phase = sfp_pkg::SFP_IGNORE;
							end
							sfp_pkg::SFP_MEM_RD: begin
								// input bits are not looked at here
								slaveNext.loadPend = 1'b1;
							end
							sfp_pkg::SFP_MEM_WR: begin
								// commit at the eighth bit; guard pin plays no part
								if (slaveReg.stopped) begin
									slaveNext.stopped = 1'b1;
								end else if (sfp_is_prot(slaveReg.addr,
									{slaveReg.protHi, slaveReg.protLo})) begin
									slaveNext.stopped = 1'b1;
								end else if (slaveReg.wLatch) begin
									slaveNext.pendValid = 1'b1;
									slaveNext.pendWord  = {slaveReg.addr, inByte};
									slaveNext.addr      =
										slaveReg.addr + `SFP_ADDR_STEP;
								end
							end
							default: begin
								// ignore phase: bits counted, nothing acted on
								slaveNext.phase = slaveReg.phase;
							end
						endcase
					end
				end
			end
		end
	end

	// single register for the whole state; reset gives all-zero state, selectors reload from storage in the first cycle after
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			slaveReg <= '0;
		end else begin
			slaveReg <= slaveNext;
		end
	end

	// two-entry buffer absorbs a stall of the array port
	sfp_two_buf #(
		.WIDTH (`SFP_WORD_W),
		.DEPTH (`SFP_BUF_DEPTH)
	) u_wrbuf (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.bus     (wrBus)
	);

	// buffer hookup; a byte waits in pendWord while the buffer is full
	assign wrBus.inValid  = slaveReg.pendValid;
	assign wrBus.inData   = slaveReg.pendWord;
	assign wrBus.outReady = memWrReady;
	assign memWrValid     = wrBus.outValid;
	assign memWrAddr      = wrBus.outData[`SFP_WORD_W-1:`SFP_DATA_W];
	assign memWrData      = wrBus.outData[`SFP_DATA_W-1:0];

	// output pin released while paused; bit survives the pause
	assign soOut       = slaveReg.soBit;
	assign soOe        = slaveReg.oeDrv & ~slaveReg.paused;
	assign memRdAddr   = slaveReg.addr;
	assign nvProtOut   = {slaveReg.guardEn, slaveReg.protHi, slaveReg.protLo};
	assign nvProtStore = slaveReg.nvStore;

endmodule

// ---- test/sfp_fram_slave_checker.sv ----
// concurrent checks on the serial memory slave ports
`timescale 1ns/1ps
module sfp_fram_slave_checker (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        csN,
	input wire logic        sck,
	input wire logic        si,
	input wire logic        holdN,
	input wire logic        wpN,
	input wire logic        soOut,
	input wire logic        soOe,
	input wire logic [12:0] memRdAddr,
	input wire logic [7:0]  memRdData,
	input wire logic        memWrValid,
	input wire logic        memWrReady,
	input wire logic [12:0] memWrAddr,
	input wire logic [7:0]  memWrData,
	input wire logic [2:0]  nvProtIn,
	input wire logic [2:0]  nvProtOut,
	input wire logic        nvProtStore
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// protected range per selector code
	function automatic logic isProt(input logic [1:0] s, input logic [12:0] a);
		return (s == 2'h3) || (s == 2'h2 && a[12]) || (s == 2'h1 && a[12:11] == 2'h3);
	endfunction
	// long enough for the synchronisers to pass a pin level
	sequence sDesel; csN[*8]; endsequence
	sequence sPaused; (!holdN)[*6]; endsequence
	sequence sSckHigh; (sck && soOe)[*5]; endsequence
	property pReset;
		@(posedge clk_sys) disable iff (1'b0)
		!rst_n |=> !soOe && !memWrValid && !nvProtStore && nvProtOut == 3'h0;
	endproperty
	chk_reset_vals: assert property (pReset) else $error("outputs not cleared by reset");
	chk_desel_quiet: assert property (sDesel |-> !soOe) else $error("so driven deselected");
	chk_pause_quiet: assert property (sPaused |-> !soOe) else $error("so driven in pause");
	chk_out_stable: assert property (sSckHigh |-> $stable(soOut)) else $error("so moved");
	chk_store_pulse: assert property (nvProtStore |=> !nvProtStore) else $error("long store");
	chk_store_follow: assert property ($past(rst_n) && $past(rst_n, 2) && $changed(nvProtOut)
		|-> ##[0:2] nvProtStore) else $error("selector change not stored");
	chk_guard_block: assert property (nvProtStore |-> !($past(nvProtOut[2], 4) && !wpN
		&& !$past(wpN, 8))) else $error("status write past guard");
	chk_word_hold: assert property (memWrValid && !memWrReady |=> memWrValid
		&& $stable(memWrAddr) && $stable(memWrData)) else $error("stalled word lost");
	chk_prot_lock: assert property (memWrValid |-> !isProt(nvProtOut[1:0], memWrAddr))
		else $error("write to protected address");
endmodule

bind sfp_fram_slave sfp_fram_slave_checker chk (.clk_sys(clk_sys), .rst_n(rst_n), .csN(csN),
	.sck(sck), .si(si), .holdN(holdN), .wpN(wpN), .soOut(soOut), .soOe(soOe),
	.memRdAddr(memRdAddr), .memRdData(memRdData), .memWrValid(memWrValid),
	.memWrReady(memWrReady), .memWrAddr(memWrAddr), .memWrData(memWrData),
	.nvProtIn(nvProtIn), .nvProtOut(nvProtOut), .nvProtStore(nvProtStore));

// ---- test/sfp_spi_master.sv ----
// behavioural serial bus master driving the slave pins
`timescale 1ns/1ps
module sfp_spi_master (
	output logic      csN,
	output logic      sck,
	output logic      si,
	output logic      holdN,
	input  wire logic soOut,
	input  wire logic soOe
);
	logic modeHi = 1'b0; // idle clock level, chosen by the bench
	initial begin
		csN = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		holdN = 1'b1;
	end
	// select with the clock at its idle level, which picks the mode
	task automatic begin_f();
		sck <= modeHi;
		#50 csN <= 1'b0;
		#62.5;
	endtask
	// one byte each way, msb first, sampling at the rising edge
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck <= 1'b0;
			si <= tx[i];
			#62.5 sck <= 1'b1;
			rx[i] = soOe ? soOut : 1'bx; // a released line never passes as data
			#62.5;
		end
	endtask
	// clock back to idle, then deselect; data line stops showing old value
	task automatic end_f();
		sck <= modeHi;
		#62.5 csN <= 1'b1;
		si <= ~si;
		#300;
	endtask
	// pause with clock low, then wiggle the clock which must be ignored
	task automatic hold_on();
		sck <= 1'b0;
		#62.5 holdN <= 1'b0;
		#62.5 sck <= 1'b1;
		#62.5 sck <= 1'b0;
		#62.5;
	endtask
	task automatic hold_off();
		holdN <= 1'b1;
		#62.5;
	endtask
endmodule

// ---- test/spi_fram_protect_and_access_tb.sv ----
// self-checking bench for the serial memory protection and access slave
`timescale 1ns/1ps
module spi_fram_protect_and_access_tb;
	logic        clk_sys, rst_n, wpN, memWrReady;
	wire logic   csN, sck, si, holdN, soOut, soOe, memWrValid, nvProtStore;
	wire logic [12:0] memRdAddr, memWrAddr;
	wire logic [7:0]  memWrData;
	wire logic [2:0]  nvProtOut;
	logic [7:0]  mem [0:8191]; // array model behind the slave
	logic [7:0]  rx;
	logic [2:0]  nvCell = 3'h0; // selector storage model, empty as shipped
	int          error_cnt = 0;
	int          n_tests = 0;
	wire logic [7:0]  memRdData = mem[memRdAddr];

	sfp_fram_slave dut (.clk_sys(clk_sys), .rst_n(rst_n), .csN(csN), .sck(sck), .si(si),
		.holdN(holdN), .wpN(wpN), .soOut(soOut), .soOe(soOe), .memRdAddr(memRdAddr),
		.memRdData(memRdData), .memWrValid(memWrValid), .memWrReady(memWrReady),
		.memWrAddr(memWrAddr), .memWrData(memWrData), .nvProtIn(nvCell),
		.nvProtOut(nvProtOut), .nvProtStore(nvProtStore));
	sfp_spi_master m (.csN(csN), .sck(sck), .si(si), .holdN(holdN), .soOut(soOut),
		.soOe(soOe));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// array takes a word on each handshake; storage keeps selectors across reset
	always @(posedge clk_sys) begin
		if (memWrValid === 1'b1 && memWrReady) mem[memWrAddr] <= memWrData;
		if (nvProtStore === 1'b1) nvCell <= nvProtOut;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic isProt(input logic [1:0] s, input logic [12:0] a);
		return (s == 2'h3) || (s == 2'h2 && a[12]) || (s == 2'h1 && a[12:11] == 2'h3);
	endfunction
	task automatic cmd1(input logic [7:0] op);
		m.begin_f();
		m.xfer(op, rx);
		m.end_f();
	endtask
	task automatic rd_status();
		logic [7:0] tail; // byte after the status byte, line must stay released
		m.begin_f();
		m.xfer(8'h05, rx);
		m.xfer(8'h00, rx);
		m.xfer(8'h00, tail);
		m.end_f();
		check(tail, 8'hxx);
	endtask
	// latch set in its own frame, then the status byte
	task automatic wr_status(input logic [7:0] v);
		cmd1(8'h06);
		m.begin_f();
		m.xfer(8'h01, rx);
		m.xfer(v, rx);
		m.end_f();
	endtask
	task automatic wr_mem(input logic [15:0] a, input logic [7:0] d0, input int n,
		input logic write_latch_flag);
		if (write_latch_flag) cmd1(8'h06);
		m.begin_f();
		m.xfer(8'h02, rx);
		m.xfer(a[15:8], rx);
		m.xfer(a[7:0], rx);
		for (int i = 0; i < n; i++) m.xfer(d0 + 8'(i), rx);
		m.end_f();
	endtask

	task automatic t_status();
		rd_status();
		check(rx, 8'h00);
		cmd1(8'h06);
		rd_status();
		check(rx, 8'h02);
		cmd1(8'h04);
		rd_status();
		check(rx, 8'h00);
		m.begin_f();
		m.xfer(8'h07, rx);
		m.xfer(8'h00, rx);
		m.end_f();
		check(rx, 8'hxx);
		m.modeHi = 1'b1;
		wr_status(8'hff);
		rd_status();
		check(rx, 8'h8c);
		check({5'h0, nvProtOut}, 8'h07);
		m.begin_f();
		m.xfer(8'h01, rx);
		m.xfer(8'h00, rx);
		m.end_f();
		rd_status();
		check(rx, 8'h8c);
		m.modeHi = 1'b0;
	endtask
	// guard enable is set: a low guard pin refuses the status write
	task automatic t_guard();
		@(posedge clk_sys) wpN <= 1'b0;
		wr_status(8'h00);
		rd_status();
		check(rx, 8'h8c);
		@(posedge clk_sys) wpN <= 1'b1;
		wr_status(8'h00);
		rd_status();
		check(rx, 8'h00);
		// guard enable clear: a low guard pin is ignored
		@(posedge clk_sys) wpN <= 1'b0;
		wr_status(8'h0c);
		rd_status();
		check(rx, 8'h0c);
		@(posedge clk_sys) wpN <= 1'b1;
	endtask
	// reset in mid-run: selectors come back from storage, the latch does not
	task automatic t_restart();
		@(posedge clk_sys) rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk_sys);
		check({5'h0, nvProtOut}, 8'h07);
		rd_status();
		check(rx, 8'h8c);
	endtask
	// every selector code against four region boundaries
	task automatic t_decode();
		logic [12:0] a;
		logic [7:0]  old, v;
		for (int s = 0; s < 4; s++) begin
			wr_status({4'h0, 2'(s), 2'h0});
			for (int j = 0; j < 4; j++) begin
				a = 13'(j) << 11;
				old = mem[a];
				v = 8'(16 * s + j) ^ 8'hc3;
				wr_mem({3'h0, a}, v, 1, 1'b1);
				check(mem[a], isProt(2'(s), a) ? old : v);
			end
		end
	endtask
	// burst into the protected quarter with the array stalled
	task automatic t_burst();
		logic [7:0] old;
		wr_status(8'h04);
		old = mem[13'h1800];
		@(posedge clk_sys) wpN <= 1'b0;
		memWrReady <= 1'b0;
		wr_mem(16'hf7fe, 8'ha0, 4, 1'b1);
		check({7'h0, memWrValid}, 8'h01);
		@(posedge clk_sys) memWrReady <= 1'b1;
		wpN <= 1'b1;
		for (int i = 0; i < 20 && memWrValid !== 1'b0; i++) @(posedge clk_sys);
		#1 check({7'h0, memWrValid}, 8'h00);
		check(mem[13'h17fe], 8'ha0);
		check(mem[13'h17ff], 8'ha1);
		check(mem[13'h1800], old);
		rd_status();
		check(rx, 8'h04);
		old = mem[13'h0000];
		wr_mem(16'h0000, 8'h99, 1, 1'b0);
		check(mem[13'h0000], old);
		wr_status(8'h00);
		wr_mem(16'h1fff, 8'h11, 2, 1'b1);
		check(mem[13'h1fff], 8'h11);
		check(mem[13'h0000], 8'h12);
	endtask
	// wrapping read in clock-idle-high mode with a pause between bytes
	task automatic t_read();
		m.modeHi = 1'b1;
		m.begin_f();
		m.xfer(8'h03, rx);
		m.xfer(8'hff, rx);
		m.xfer(8'hff, rx);
		m.xfer(8'hff, rx);
		check(rx, 8'h11);
		m.hold_on();
		#200 check({7'h0, soOe}, 8'h00);
		m.hold_off();
		m.xfer(8'h00, rx);
		check(rx, 8'h12);
		m.end_f();
		check({7'h0, soOe}, 8'h00);
		m.modeHi = 1'b0;
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 8192; i++) mem[i] = 8'(i) ^ 8'h5a;
		rst_n = 1'b0;
		wpN = 1'b1;
		memWrReady = 1'b1;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk_sys);
		t_status();
		t_restart();
		t_guard();
		t_decode();
		t_burst();
		t_read();
		report_and_stop();
	end
	// the whole run needs well under half of this span
	initial begin
		#1_000_000;
		error_cnt++;
		report_and_stop();
	end
endmodule
